/* File: tb/gio_pins_model.sv */
// Board side of the port pins: external drivers, one pull-up, floating pads.
// Assumes the bench keeps its drivers off pins that the block drives.
`default_nettype none
module gio_pins_model
  import gio_pkg::*;
(
  input wire logic clk,
  input wire gio_pads_s padOut,
  input wire gio_pads_s padOe,
  input wire gio_pads_s extVal,
  input wire gio_pads_s extEn,
  output gio_pads_s padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_r = 1'h0;
  always @(posedge clk) flip_r <= ~flip_r;
  // Floating pads toggle so a stale level never passes for a read
  always_comb
  begin
    for (int i = 0; i < 14; i++)
      padIn[i] = padOe[i] ? padOut[i] : (extEn[i] ? extVal[i] : flip_r ^ i[0]);
    if (!padOe.a[4] && !extEn.a[4])
      padIn.a[4] = 1'h1;
  end
endmodule : gio_pins_model
`default_nettype wire

/* File: tb/gio_port_properties.sv */
// Pin and bus checks for the I/O port block.
// Assumes it is bound onto gio_port; one clock, sync reset.
`default_nettype none
`include "gio_map.svh"
module gio_port_properties
  import gio_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`GIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [`GIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire gio_pads_s padIn,
  input wire gio_pads_s padOut,
  input wire gio_pads_s padOe,
  input wire logic sspEnable,
  input wire logic timerExtClockIn,
  input wire logic slaveSelectIn,
  input wire logic [`GIO_A_W-1:0] analogSelect
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Write decode; settle count hides stale synchroniser history
  // ----
  logic wrGo;
  logic wrDirA;
  logic wrDirB;
  logic wrLatB;
  logic [1:0] upCnt_r;
  assign wrGo = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_wstrb[0];
  assign wrDirA = wrGo && s_axi_awaddr == {`GIO_IDX_PORT_A_DIRECTION, 2'h0};
  assign wrDirB = wrGo && s_axi_awaddr == {`GIO_IDX_PORT_B_DIRECTION, 2'h0};
  assign wrLatB = wrGo && !s_axi_wstrb[1] && s_axi_awaddr == {`GIO_IDX_PORT_B_DATA, 2'h0};
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      upCnt_r <= 2'h0;
    else if (upCnt_r != 2'h3)
      upCnt_r <= upCnt_r + 2'h1;
  end
  // Remembers whether the read now answered addressed a port A register
  logic rdA_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdA_r <= 1'h0;
    else if (s_axi_arvalid && s_axi_arready)
      rdA_r <= (s_axi_araddr == {`GIO_IDX_PORT_A_DATA, 2'h0})
        || (s_axi_araddr == {`GIO_IDX_PORT_A_DIRECTION, 2'h0});
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_OD_LOW: assert property (padOut.a[4] == 1'h0)
    else $error("open-drain pin driven high");
  AST_TMR_CLK: assert property (upCnt_r == 2'h3
    |-> timerExtClockIn == $past(padIn.a[4], 2))
    else $error("timer clock not the synced pin");
  AST_SS_IN: assert property (upCnt_r == 2'h3
    |-> slaveSelectIn == $past(padIn.a[5], 2))
    else $error("slave select not the synced pin");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("unused read bits not zero");
  AST_RD_A_TOP: assert property (s_axi_rvalid && rdA_r |-> s_axi_rdata[7:6] == 2'h0)
    else $error("port A upper bits not zero");
  AST_DIRB_OE: assert property (wrDirB
    |-> ##2 padOe.b == ~$past(s_axi_wdata[7:0], 2))
    else $error("port B enables do not follow direction");
  AST_DIRA_OE: assert property (wrDirA
    |-> ##2 padOe.a[3:0] == ~$past(s_axi_wdata[3:0], 2))
    else $error("port A enables do not follow direction");
  AST_LATB_OUT: assert property (wrLatB
    |-> ##2 padOut.b == $past(s_axi_wdata[7:0], 2))
    else $error("port B outputs do not follow latch");
  AST_SSP_OFF: assert property ($past(sspEnable) |-> !padOe.a[5])
    else $error("slave select pin driven while serial port on");
  AST_RST_ANALOG: assert property ($fell(sys_rst)
    |-> analogSelect == 6'h2f && padOe == 14'h0000)
    else $error("reset state of pins wrong");
  COV_DIRB: cover property (wrDirB);
  COV_SSP: cover property (sspEnable);
  COV_TMR: cover property ($fell(timerExtClockIn));
endmodule : gio_port_properties
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the I/O port block with a pin model.
// Assumes gio_map.svh on the include path; one 25 MHz clock.
`default_nettype none
`include "gio_map.svh"
module tb_top
  import gio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] AD_A = {`GIO_IDX_PORT_A_DATA, 2'h0};
  localparam logic [11:0] AD_B = {`GIO_IDX_PORT_B_DATA, 2'h0};
  localparam logic [11:0] DR_A = {`GIO_IDX_PORT_A_DIRECTION, 2'h0};
  localparam logic [11:0] DR_B = {`GIO_IDX_PORT_B_DIRECTION, 2'h0};
  localparam logic [11:0] CFG = {`GIO_IDX_ANALOG_PIN_CONFIG, 2'h0};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] awAddr = 12'h000;
  logic [11:0] arAddr = 12'h000;
  logic [31:0] wData = 32'h0000_0000;
  logic [3:0] wStrb = 4'h0;
  logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
  logic sspEn = 1'h0;
  logic awReady, wReady, bValid, arReady, rValid, tmrClk, ssIn, refSel;
  logic [1:0] bResp, rResp, resp;
  logic [31:0] rData, rd;
  logic [5:0] anaSel;
  gio_pads_s padIn, padOut, padOe;
  gio_pads_s extVal = 14'h3fff;
  gio_pads_s extEn = 14'h3fff;
  logic [6:0] cfgTab [8] = '{7'h2f, 7'h6f, 7'h07, 7'h4b, 7'h01, 7'h49, 7'h00, 7'h00};
  int errors = 0;
  int total_checks = 0;
  gio_port gio_port_inst (.clk(clk), .sys_rst(rst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .sspEnable(sspEn), .timerExtClockIn(tmrClk), .slaveSelectIn(ssIn),
    .analogSelect(anaSel), .refPinSelect(refSel));
  gio_pins_model gio_pins_model_inst (.clk(clk), .padOut(padOut), .padOe(padOe),
    .extVal(extVal), .extEn(extEn), .padIn(padIn));
  initial forever #20 clk = ~clk;
  // ----
  // Bus and compare tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awReady) awValid <= 1'h0;
      if (wReady) wValid <= 1'h0;
    end
    while ((awValid && !awReady) || (wValid && !wReady));
    do @(posedge clk); while (!bValid);
    resp = bResp;
    bReady <= 1'h0;
  endtask : axiWr
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= 1'h1;
    do @(posedge clk); while (!arReady);
    arValid <= 1'h0;
    do @(posedge clk); while (!rValid);
    rd = rData;
    resp = rResp;
    rReady <= 1'h0;
    check(rd, e);
  endtask : rdChk
  // ----
  // Scenarios
  // ----
  task automatic tReset();
    check(padOe, 14'h0000);
    rdChk(DR_A, 32'h0000_003f);
    rdChk(DR_B, 32'h0000_00ff);
    rdChk(CFG, 32'h0000_0000);
    rdChk(AD_A, 32'h0000_0010);
  endtask : tReset
  task automatic tPortB();
    @(posedge clk);
    extEn.b <= 8'h00;
    axiWr(AD_B, 32'h0000_00a5);
    axiWr(DR_B, 32'h0000_00f0);
    settle();
    check(padOe.b, 8'h0f);
    check(padOut.b, 8'ha5);
    @(posedge clk);
    extVal.b <= 8'h50;
    extEn.b <= 8'hf0;
    settle();
    rdChk(AD_B, 32'h0000_0055);
    axiWr(AD_B, 32'h0000_0f0c, 4'h3);
    @(posedge clk);
    extEn.b <= 8'h00;
    axiWr(DR_B, 32'h0000_0000);
    settle();
    check(padOut.b, 8'h5c);
    check(padOe.b, 8'hff);
  endtask : tPortB
  task automatic tCfg();
    for (int i = 0; i < 8; i++)
    begin
      axiWr(CFG, i);
      settle();
      rdChk(CFG, i);
      check({refSel, anaSel}, cfgTab[i]);
      rdChk(AD_A, 6'h3f & ~cfgTab[i][5:0]);
    end
    check({tmrClk, ssIn}, 2'h3);
    @(posedge clk);
    extVal.a <= 6'h2f;
    settle();
    check(tmrClk, 1'h0);
    rdChk(AD_A, 32'h0000_002f);
  endtask : tCfg
  task automatic tPortA();
    @(posedge clk);
    extEn.a <= 6'h00;
    axiWr(AD_A, 32'h0000_0000);
    axiWr(DR_A, 32'h0000_0000);
    settle();
    check({padOe.a, padOut.a}, 12'hfc0);
    axiWr(AD_A, 32'h0000_003f);
    settle();
    check({padOe.a, padOut.a}, 12'hbef);
    rdChk(AD_A, 32'h0000_003f);
    @(posedge clk);
    sspEn <= 1'h1;
    settle();
    check(padOe.a[5], 1'h0);
    @(posedge clk);
    sspEn <= 1'h0;
    axiWr(CFG, 32'h0000_0000);
    settle();
    check(padOe.a, 6'h2f);
    check(anaSel, 6'h2f);
    axiWr(DR_A, 32'h0000_003f);
    settle();
    check(padOe.a, 6'h00);
  endtask : tPortA
  task automatic tBad();
    rdChk(12'h100, 32'h0000_0000);
    check(resp, `GIO_RESP_SLVERR);
    axiWr(12'h3fc, 32'h0000_00ff);
    check(resp, `GIO_RESP_SLVERR);
    rdChk(DR_A, 32'h0000_003f);
  endtask : tBad
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  initial
  begin
    #60us;
    errors++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    tReset();
    tPortB();
    tCfg();
    tPortA();
    tBad();
    results();
  end
endmodule : tb_top
bind gio_port gio_port_properties gio_port_properties_inst (.clk(clk), .sys_rst(sys_rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .padIn(padIn), .padOut(padOut), .padOe(padOe), .sspEnable(sspEnable),
  .timerExtClockIn(timerExtClockIn), .slaveSelectIn(slaveSelectIn),
  .analogSelect(analogSelect));
`default_nettype wire

/* File: verilog/gio_map.svh */
// Register offsets, field positions, reset values and bus codes of the I/O port block.
// Assumes nothing beyond being included by its bare name before use.
`ifndef GIO_MAP_SVH
`define GIO_MAP_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------
`define GIO_IDX_PORT_A_DATA 10'h005
`define GIO_IDX_PORT_B_DATA 10'h006
`define GIO_IDX_PORT_A_DIRECTION 10'h085
`define GIO_IDX_PORT_B_DIRECTION 10'h086
`define GIO_IDX_ANALOG_PIN_CONFIG 10'h09f

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define GIO_A_W 6
`define GIO_B_W 8
`define GIO_ADDR_W 12
`define GIO_CFG_W 3
`define GIO_BIT_REF 3
`define GIO_BIT_OPEN_DRAIN 4
`define GIO_BIT_SLAVE_SEL 5
`define GIO_MASK_LSB 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GIO_RST_DIR_A 6'h3f
`define GIO_RST_DIR_B 8'hff
`define GIO_RST_LATCH_A 6'h00
`define GIO_RST_LATCH_B 8'h00
`define GIO_RST_CFG 3'h0

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define GIO_RESP_OKAY 2'h0
`define GIO_RESP_SLVERR 2'h2

`endif

/* File: verilog/gio_pkg.sv */
// Types shared by the I/O port block and its pin synchroniser.
// Assumes gio_map.svh is on the include path.
`default_nettype none
`include "gio_map.svh"

package gio_pkg;

  typedef struct packed {
    logic [`GIO_B_W-1:0] b;
    logic [`GIO_A_W-1:0] a;
  } gio_pads_s;

  typedef struct packed {
    gio_pads_s stage1;
    gio_pads_s stage2;
  } gio_sync_s;

  typedef enum logic [1:0] {
    GIO_WR_IDLE = 2'b00,
    GIO_WR_DO = 2'b01,
    GIO_WR_RESP = 2'b11
  } gio_wr_e;

  typedef struct packed {
    logic [`GIO_A_W-1:0] dirA;
    logic [`GIO_A_W-1:0] latchA;
    logic [`GIO_B_W-1:0] dirB;
    logic [`GIO_B_W-1:0] latchB;
    logic [`GIO_CFG_W-1:0] cfg;
    logic [`GIO_A_W-1:0] anaMask;
    logic refSel;
    gio_pads_s padOut;
    gio_pads_s padOe;
    gio_wr_e wrState;
    logic awHeld;
    logic [`GIO_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } gio_state_s;

endpackage : gio_pkg

`default_nettype wire

/* File: verilog/gio_port.sv */
// Six-bit and eight-bit general-purpose I/O ports behind an AXI4-Lite slave.
// Assumes one 25 MHz clock, synchronous active-high reset, and a pad ring that
// resolves each pin from its output and output enable.
//
// Operation
// - Direction one tri-states the pin driver
// - Direction zero drives pin from latch
// - Data read returns sampled pin levels
// - Writes merge sampled pins into whole latch
// - Bit four open-drain, pulls low only
// - Bit four also clocks the timer
// - Config field picks analog or digital use
// - Reset leaves analog pins reading zero; bit four stays digital
// - Direction still drives analog pins; keep set
// - Upper two bits of port A read zero
// - Bit five slave select, bit three reference
// - Enabled peripheral takes its shared pin
// - Port B eight bits with direction register
// - Port B direction one input, zero drives
//
// The AXI4-Lite interface to the registers was left to the implementer.
`default_nettype none
`include "gio_map.svh"

module gio_port
  import gio_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`GIO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`GIO_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire gio_pads_s padIn,
  output gio_pads_s padOut,
  output gio_pads_s padOe,
  input wire logic sspEnable,
  output logic timerExtClockIn,
  output logic slaveSelectIn,
  output logic [`GIO_A_W-1:0] analogSelect,
  output logic refPinSelect
);

  gio_state_s st_r;
  gio_state_s st_nxt;
  gio_pads_s pinSync;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  gio_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .padIn(padIn),
    .padSync(pinSync)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`GIO_ADDR_W-1:0] byte_addr(input logic [9:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  // Returns {reference select, analog mask}; bit four is never analog
  function automatic logic [`GIO_A_W:0] cfg_decode(input logic [`GIO_CFG_W-1:0] c);
    case (c)
      3'h0: cfg_decode = {1'b0, 6'h2f};
      3'h1: cfg_decode = {1'b1, 6'h2f};
      3'h2: cfg_decode = {1'b0, 6'h07};
      3'h3: cfg_decode = {1'b1, 6'h0b};
      3'h4: cfg_decode = {1'b0, 6'h01};
      3'h5: cfg_decode = {1'b1, 6'h09};
      default: cfg_decode = {1'b0, 6'h00};
    endcase
  endfunction : cfg_decode

  function automatic logic mapped(input logic [`GIO_ADDR_W-1:0] a);
    mapped = (a == byte_addr(`GIO_IDX_PORT_A_DATA))
      || (a == byte_addr(`GIO_IDX_PORT_B_DATA))
      || (a == byte_addr(`GIO_IDX_PORT_A_DIRECTION))
      || (a == byte_addr(`GIO_IDX_PORT_B_DIRECTION))
      || (a == byte_addr(`GIO_IDX_ANALOG_PIN_CONFIG));
  endfunction : mapped

  // ----------------------------------------------------------------
  // Pin read values
  // ----------------------------------------------------------------
  // Analog pins read zero so a floating analog level never reaches software
  logic [`GIO_A_W-1:0] pinReadA;
  logic [`GIO_B_W-1:0] pinReadB;
  logic [`GIO_A_W-1:0] wrMaskA;
  logic [`GIO_B_W-1:0] wrMaskB;
  logic [`GIO_A_W:0] cfgDec;

  // Timer clock pin is never analog, so its level always reaches software
  genvar pinIdx;
  generate
    for (pinIdx = 0; pinIdx < `GIO_A_W; pinIdx++)
    begin : g_read_a
      if (pinIdx == `GIO_BIT_OPEN_DRAIN)
      begin : g_digital
        assign pinReadA[pinIdx] = pinSync.a[pinIdx];
      end
      else
      begin : g_shared
        assign pinReadA[pinIdx] = pinSync.a[pinIdx] & ~st_r.anaMask[pinIdx];
      end
    end
  endgenerate
  assign pinReadB = pinSync.b;

  // Byte lane one, when enabled, picks which bits take write data; the rest take the sampled pins
  assign wrMaskA = st_r.wStrb[1] ? st_r.wData[`GIO_MASK_LSB +: `GIO_A_W] : '1;
  assign wrMaskB = st_r.wStrb[1] ? st_r.wData[`GIO_MASK_LSB +: `GIO_B_W] : '1;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    cfgDec = '0;

    // Write channels: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end

    case (st_r.wrState)
      GIO_WR_IDLE:
      begin
        if (st_nxt.awHeld && st_nxt.wHeld)
        begin
          st_nxt.wrState = GIO_WR_DO;
        end
      end
      GIO_WR_DO:
      begin
        st_nxt.awHeld = 1'b0;
        st_nxt.wHeld = 1'b0;
        st_nxt.wrState = GIO_WR_RESP;
        st_nxt.bResp = mapped(st_r.awAddr) ? `GIO_RESP_OKAY : `GIO_RESP_SLVERR;
        if (st_r.wStrb[0])
        begin
          if (st_r.awAddr == byte_addr(`GIO_IDX_PORT_A_DATA))
          begin
            // Pins sampled now fill every bit outside the mask
            st_nxt.latchA = (pinReadA & ~wrMaskA)
              | (st_r.wData[`GIO_A_W-1:0] & wrMaskA);
          end
          if (st_r.awAddr == byte_addr(`GIO_IDX_PORT_B_DATA))
          begin
            st_nxt.latchB = (pinReadB & ~wrMaskB)
              | (st_r.wData[`GIO_B_W-1:0] & wrMaskB);
          end
          if (st_r.awAddr == byte_addr(`GIO_IDX_PORT_A_DIRECTION))
          begin
            st_nxt.dirA = st_r.wData[`GIO_A_W-1:0];
          end
          if (st_r.awAddr == byte_addr(`GIO_IDX_PORT_B_DIRECTION))
          begin
            st_nxt.dirB = st_r.wData[`GIO_B_W-1:0];
          end
          if (st_r.awAddr == byte_addr(`GIO_IDX_ANALOG_PIN_CONFIG))
          begin
            st_nxt.cfg = st_r.wData[`GIO_CFG_W-1:0];
          end
        end
      end
      GIO_WR_RESP:
      begin
        if (s_axi_bready)
        begin
          st_nxt.wrState = GIO_WR_IDLE;
        end
      end
      default:
      begin
        st_nxt.wrState = GIO_WR_IDLE;
      end
    endcase

    // Read channel: answer one cycle after the address is taken
    if (st_r.rValid && s_axi_rready)
    begin
      st_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp = mapped(s_axi_araddr) ? `GIO_RESP_OKAY : `GIO_RESP_SLVERR;
      st_nxt.rData = '0;
      if (s_axi_araddr == byte_addr(`GIO_IDX_PORT_A_DATA))
      begin
        st_nxt.rData[`GIO_A_W-1:0] = pinReadA;
      end
      if (s_axi_araddr == byte_addr(`GIO_IDX_PORT_B_DATA))
      begin
        st_nxt.rData[`GIO_B_W-1:0] = pinReadB;
      end
      if (s_axi_araddr == byte_addr(`GIO_IDX_PORT_A_DIRECTION))
      begin
        st_nxt.rData[`GIO_A_W-1:0] = st_r.dirA;
      end
      if (s_axi_araddr == byte_addr(`GIO_IDX_PORT_B_DIRECTION))
      begin
        st_nxt.rData[`GIO_B_W-1:0] = st_r.dirB;
      end
      if (s_axi_araddr == byte_addr(`GIO_IDX_ANALOG_PIN_CONFIG))
      begin
        st_nxt.rData[`GIO_CFG_W-1:0] = st_r.cfg;
      end
    end

    // Pin function from the configuration field
    cfgDec = cfg_decode(st_nxt.cfg);
    st_nxt.anaMask = cfgDec[`GIO_A_W-1:0];
    st_nxt.refSel = cfgDec[`GIO_A_W];

    // Drivers follow direction even on analog pins
    st_nxt.padOe.a = ~st_nxt.dirA;
    st_nxt.padOut.a = st_nxt.latchA;

    // Open drain: only ever sinks, high level comes from the board
    st_nxt.padOut.a[`GIO_BIT_OPEN_DRAIN] = 1'b0;
    st_nxt.padOe.a[`GIO_BIT_OPEN_DRAIN] = ~st_nxt.dirA[`GIO_BIT_OPEN_DRAIN]
      & ~st_nxt.latchA[`GIO_BIT_OPEN_DRAIN];

    // Serial port slave select owns its pin as an input
    if (sspEnable)
    begin
      st_nxt.padOe.a[`GIO_BIT_SLAVE_SEL] = 1'b0;
    end

    st_nxt.padOe.b = ~st_nxt.dirB;
    st_nxt.padOut.b = st_nxt.latchB;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
      st_r.dirA <= `GIO_RST_DIR_A;
      st_r.latchA <= `GIO_RST_LATCH_A;
      st_r.dirB <= `GIO_RST_DIR_B;
      st_r.latchB <= `GIO_RST_LATCH_B;
      st_r.cfg <= `GIO_RST_CFG;
      st_r.anaMask <= 6'h2f;
      st_r.wrState <= GIO_WR_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Holding off new addresses until the response drains keeps one write in flight
  assign s_axi_awready = !st_r.awHeld && (st_r.wrState == GIO_WR_IDLE);
  assign s_axi_wready = !st_r.wHeld && (st_r.wrState == GIO_WR_IDLE);
  assign s_axi_bvalid = (st_r.wrState == GIO_WR_RESP);
  assign s_axi_bresp = st_r.bResp;
  assign s_axi_arready = !st_r.rValid;
  assign s_axi_rvalid = st_r.rValid;
  assign s_axi_rdata = st_r.rData;
  assign s_axi_rresp = st_r.rResp;

  assign padOut = st_r.padOut;
  assign padOe = st_r.padOe;

  // Timer and serial port see the synchronised pin whatever its port use
  assign timerExtClockIn = pinSync.a[`GIO_BIT_OPEN_DRAIN];
  assign slaveSelectIn = pinSync.a[`GIO_BIT_SLAVE_SEL];
  assign analogSelect = st_r.anaMask;
  assign refPinSelect = st_r.refSel;

endmodule : gio_port

`default_nettype wire

/* File: verilog/gio_sync.sv */
// Two-stage synchroniser for every pad input of both ports.
// Assumes pad levels are asynchronous to clk; reset is synchronous, active high.
`default_nettype none

module gio_sync
  import gio_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire gio_pads_s padIn,
  output gio_pads_s padSync
);

  gio_sync_s st_r;
  gio_sync_s st_nxt;

  // ----------------------------------------------------------------
  // Stage one is read only by stage two
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.stage1 = padIn;
    st_nxt.stage2 = st_r.stage1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign padSync = st_r.stage2;

endmodule : gio_sync

`default_nettype wire
